// [rtl/vdb_autocal.sv]
// Valve dead-band auto-calibration engine with APB register access
`timescale 1ns/1ns
module vdb_autocal
    import vdb_pkg::*;
#(
    parameter int TICK_CYCLES = MS_CYCLES
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sensors
    input wire logic [XW-1:0] wheel_pos,
    input wire logic wheel_motion,
    // Spool drive
    output logic [XW-1:0] spool_setpoint,
    // Bus status messages
    output vdb_status_t status_msg,
    // Non-volatile memory
    output vdb_nvm_wr_t nvm_wr,
    output logic nvm_commit,
    // Dead-bands in use for steering
    output logic [XW-1:0] active_db_r,
    output logic [XW-1:0] active_db_l
);
    ////////////////////////////////////////////////////////////////////////
    initial begin
        if (TICK_CYCLES < 1) begin
            $error("vdb_autocal: TICK_CYCLES must be at least 1");
        end
    end

    localparam int TW = $clog2(TICK_CYCLES + 1);

    vdb_state_t state_ff, nxt_state;
    vdb_cmd_t cmd_ff, stage_ff;
    logic calmode_ff, done_ff, aborted_ff, refused_ff, dir_ff;
    logic [XW-1:0] pidx_ff;
    logic [XW-1:0] sp_ff, sample_ff, backoff_ff, xcal_ff, delta_ff;
    logic [TW-1:0] tick_ff;
    logic [XW-1:0] ms_ff;
    logic [31:0] prdata_ff;
    vdb_status_t msg_ff;
    vdb_nvm_wr_t nvm_ff;
    logic commit_ff;
    logic [XW-1:0] act_r_ff, act_l_ff;
    logic [XW-1:0] rdata;

    ////////////////////////////////////////////////////////////////////////
    // APB decode; zero wait states
    wire setup = psel && !penable;
    wire wr_acc = psel && penable && pwrite;
    wire a_ctrl = paddr == A_CTRL;
    wire a_start = paddr == A_START;
    wire a_step = paddr == A_STEP;
    wire a_thr = paddr == A_THRESH;
    wire a_int = paddr == A_INTERVAL;
    wire a_stat = paddr == A_STATUS;
    wire a_pidx = paddr == A_PIDX;
    wire a_pdata = paddr == A_PDATA;
    wire a_spool = paddr == A_SPOOL;
    wire mapped = a_ctrl | a_start | a_step | a_thr | a_int | a_stat | a_pidx | a_pdata | a_spool;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_ff;

    wire running = state_ff inside {ST_RD_BO, ST_ARM, ST_STEP, ST_RD_DB, ST_WR_DB, ST_RD_FF, ST_WR_FF};
    wire begin_req = wr_acc && a_ctrl && pwdata[B_BEGIN];
    wire begin_ok = begin_req && calmode_ff && state_ff == ST_IDLE;
    wire abort_now = running && wheel_motion;

    ////////////////////////////////////////////////////////////////////////
    // Parameter index translation
    function automatic logic [2:0] slot_of(input logic [XW-1:0] idx);
        logic [2:0] s;
        s = SL_NONE;
        if (idx == IDX_BACKOFF) s = SL_BACKOFF;
        if (idx == IDX_DB_L) s = SL_DB_L;
        if (idx == IDX_DB_R) s = SL_DB_R;
        if (idx == IDX_FF_L) s = SL_FF_L;
        if (idx == IDX_FF_R) s = SL_FF_R;
        return s;
    endfunction

    function automatic logic [XW-1:0] idx_of(input logic [2:0] s);
        logic [XW-1:0] i;
        i = IDX_BACKOFF;
        if (s == SL_DB_L) i = IDX_DB_L;
        if (s == SL_DB_R) i = IDX_DB_R;
        if (s == SL_FF_L) i = IDX_FF_L;
        if (s == SL_FF_R) i = IDX_FF_R;
        return i;
    endfunction

    wire [2:0] pslot = slot_of(pidx_ff);
    wire [XW-1:0] pval = pwdata[XW-1:0];
    wire bo_bad = pslot == SL_BACKOFF && ($signed(pval) < 0 || $signed(pval) > BACKOFF_MAX);
    wire sw_we = wr_acc && a_pdata && !running && pslot != SL_NONE && !bo_bad;

    ////////////////////////////////////////////////////////////////////////
    // Search arithmetic
    wire [2:0] db_slot = dir_ff ? SL_DB_L : SL_DB_R;
    wire [2:0] ff_slot = dir_ff ? SL_FF_L : SL_FF_R;
    wire signed [XW-1:0] diff = $signed(wheel_pos) - $signed(sample_ff);
    wire [XW-1:0] adiff = diff[XW-1] ? XW'(-diff) : diff;
    wire flow = adiff > cmd_ff.thresh;
    wire signed [XW:0] sp_up = {sp_ff[XW-1], sp_ff} + {1'b0, cmd_ff.step};
    wire signed [XW:0] sp_dn = {sp_ff[XW-1], sp_ff} - {1'b0, cmd_ff.step};
    // Clamp to the full stroke so a missed detection cannot wrap the spool
    wire [XW-1:0] sp_r = sp_up > SP_MAX ? SP_MAX : sp_up[XW-1:0];
    wire [XW-1:0] sp_l = sp_dn < -SP_MAX ? XW'(-SP_MAX) : sp_dn[XW-1:0];
    wire [XW-1:0] start_sp = dir_ff ? XW'(-cmd_ff.start) : cmd_ff.start;
    wire [XW-1:0] new_db = dir_ff ? xcal_ff + backoff_ff : xcal_ff - backoff_ff;
    wire tick = tick_ff == TW'(TICK_CYCLES - 1);
    wire interval_end = tick && (ms_ff + 16'h0001 >= cmd_ff.interval);

    ////////////////////////////////////////////////////////////////////////
    // Store port selection
    logic [2:0] raddr;
    logic fsm_we;
    logic [2:0] fsm_waddr;
    logic [XW-1:0] fsm_wdata;

    always_comb begin
        raddr = pslot;
        unique case (state_ff)
            ST_BOOT_R: raddr = SL_DB_R;
            ST_BOOT_L: raddr = SL_DB_L;
            ST_RD_BO: raddr = SL_BACKOFF;
            ST_RD_DB: raddr = db_slot;
            ST_RD_FF: raddr = ff_slot;
            default: raddr = running ? SL_NONE : pslot;
        endcase
    end

    always_comb begin
        fsm_we = 1'b0;
        fsm_waddr = db_slot;
        fsm_wdata = new_db;
        if (state_ff == ST_WR_DB && !abort_now) begin
            fsm_we = 1'b1;
        end else if (state_ff == ST_WR_FF && !abort_now) begin
            fsm_we = 1'b1;
            fsm_waddr = ff_slot;
            fsm_wdata = rdata + delta_ff;
        end
    end

    wire st_we = fsm_we | sw_we;
    wire [2:0] st_waddr = fsm_we ? fsm_waddr : pslot;
    wire [XW-1:0] st_wdata = fsm_we ? fsm_wdata : pval;

    vdb_param_store #(
        .DW(XW),
        .DEPTH(NSLOT),
        .INIT(RST_STORE)
    ) u_store (
        .clk(pclk),
        .rst_n(presetn),
        .we(st_we),
        .waddr(st_waddr),
        .wdata(st_wdata),
        .raddr(raddr),
        .rdata(rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_BOOT_R: nxt_state = ST_BOOT_L;
            ST_BOOT_L: nxt_state = ST_IDLE;
            ST_IDLE: if (begin_ok) nxt_state = ST_RD_BO;
            ST_RD_BO: nxt_state = ST_ARM;
            ST_ARM: nxt_state = ST_STEP;
            ST_STEP: if (interval_end && flow) nxt_state = ST_RD_DB;
            ST_RD_DB: nxt_state = ST_WR_DB;
            ST_WR_DB: nxt_state = ST_RD_FF;
            ST_RD_FF: nxt_state = ST_WR_FF;
            ST_WR_FF: nxt_state = dir_ff ? ST_IDLE : ST_ARM;
        endcase
        if (abort_now) begin
            nxt_state = ST_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_BOOT_R;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control and staging registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            calmode_ff <= 1'b0;
            stage_ff <= '0;
            pidx_ff <= '0;
            refused_ff <= 1'b0;
        end else begin
            if (wr_acc && a_ctrl && pwdata[B_CAL_ENTRY]) calmode_ff <= 1'b1;
            if (wr_acc && a_start && !running) stage_ff.start <= pval;
            if (wr_acc && a_step && !running) stage_ff.step <= pval;
            if (wr_acc && a_thr && !running) stage_ff.thresh <= pval;
            if (wr_acc && a_int && !running) stage_ff.interval <= pval;
            if (wr_acc && a_pidx && !running) pidx_ff <= pval;
            if (begin_req) refused_ff <= !begin_ok;
            if (wr_acc && a_pdata) refused_ff <= !sw_we;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Search datapath
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_ff <= '0;
            dir_ff <= 1'b0;
            sp_ff <= '0;
            sample_ff <= '0;
            backoff_ff <= RST_BACKOFF;
            xcal_ff <= '0;
            delta_ff <= '0;
            tick_ff <= '0;
            ms_ff <= '0;
        end else begin
            tick_ff <= (state_ff != ST_STEP || tick) ? '0 : tick_ff + 1'b1;
            if (state_ff == ST_IDLE && begin_ok) begin
                cmd_ff <= stage_ff;
                dir_ff <= 1'b0;
            end
            if (state_ff == ST_ARM && !dir_ff) backoff_ff <= rdata;
            if (state_ff == ST_ARM) begin
                sp_ff <= start_sp;
                sample_ff <= wheel_pos;
                ms_ff <= '0;
            end
            if (state_ff == ST_STEP && tick) begin
                ms_ff <= interval_end ? '0 : ms_ff + 16'h0001;
                if (interval_end) begin
                    sample_ff <= wheel_pos;
                    if (flow) begin
                        xcal_ff <= sp_ff;
                    end else begin
                        sp_ff <= dir_ff ? sp_l : sp_r;
                    end
                end
            end
            if (state_ff == ST_WR_DB) delta_ff <= new_db - rdata;
            if (state_ff == ST_WR_FF) dir_ff <= 1'b1;
            if ((state_ff == ST_WR_FF && dir_ff) || abort_now) sp_ff <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outcome flags, messages and non-volatile writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_ff <= 1'b0;
            aborted_ff <= 1'b0;
            msg_ff <= '0;
            nvm_ff <= '0;
            commit_ff <= 1'b0;
        end else begin
            msg_ff.valid <= 1'b0;
            msg_ff.setpoint <= sp_ff;
            nvm_ff.valid <= st_we;
            nvm_ff.idx <= idx_of(st_waddr);
            nvm_ff.data <= st_wdata;
            commit_ff <= 1'b0;
            if (begin_ok) begin
                done_ff <= 1'b0;
                aborted_ff <= 1'b0;
                msg_ff.valid <= 1'b1;
                msg_ff.code <= MSG_STARTED;
            end
            if (state_ff == ST_STEP && interval_end && !abort_now) begin
                msg_ff.valid <= 1'b1;
                msg_ff.code <= flow ? (dir_ff ? MSG_FLOW_L : MSG_FLOW_R) : MSG_STEP;
            end
            if (state_ff == ST_WR_FF && dir_ff && !abort_now) begin
                done_ff <= 1'b1;
                commit_ff <= 1'b1;
                msg_ff.valid <= 1'b1;
                msg_ff.code <= MSG_COMPLETE;
            end
            if (abort_now) begin
                aborted_ff <= 1'b1;
                msg_ff.valid <= 1'b1;
                msg_ff.code <= MSG_ABORT;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Dead-bands in use are only picked up once after power-up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_r_ff <= RST_DB_R;
            act_l_ff <= RST_DB_L;
        end else begin
            if (state_ff == ST_BOOT_L) act_r_ff <= rdata;
            if (state_ff == ST_IDLE && $past(state_ff == ST_BOOT_L)) act_l_ff <= rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data captured in the setup phase
    wire [31:0] status_word = {26'h0, refused_ff, dir_ff, aborted_ff, done_ff, running, calmode_ff};
    wire [XW-1:0] pdata_rd = running ? '0 : rdata;
    wire [31:0] rd_mux =
        a_ctrl ? 32'h0 :
        a_start ? {16'h0, stage_ff.start} :
        a_step ? {16'h0, stage_ff.step} :
        a_thr ? {16'h0, stage_ff.thresh} :
        a_int ? {16'h0, stage_ff.interval} :
        a_stat ? status_word :
        a_pidx ? {16'h0, pidx_ff} :
        a_pdata ? {{16{pdata_rd[XW-1]}}, pdata_rd} :
        a_spool ? {{16{sp_ff[XW-1]}}, sp_ff} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= '0;
        end else if (setup && !pwrite) begin
            prdata_ff <= rd_mux;
        end
    end

    assign spool_setpoint = sp_ff;
    assign status_msg = msg_ff;
    assign nvm_wr = nvm_ff;
    assign nvm_commit = commit_ff;
    assign active_db_r = act_r_ff;
    assign active_db_l = act_l_ff;
endmodule

// [rtl/vdb_param_store.sv]
// Small parameter store with reset defaults and registered read data
`timescale 1ns/1ns
module vdb_param_store #(
    parameter int DW = 16,
    parameter int DEPTH = 5,
    parameter logic [DEPTH*DW-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Write port
    input wire logic we,
    input wire logic [2:0] waddr,
    input wire logic [DW-1:0] wdata,
    // Read port
    input wire logic [2:0] raddr,
    output logic [DW-1:0] rdata
);
    ////////////////////////////////////////////////////////////////////////
    initial begin
        if (DEPTH < 1 || DEPTH > 8 || DW < 1) begin
            $error("vdb_param_store: unsupported geometry");
        end
    end

    logic [DW-1:0] word_ff [DEPTH];

    generate
        for (genvar i = 0; i < DEPTH; i++) begin : g_word
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    word_ff[i] <= INIT[i*DW +: DW];
                end else if (we && waddr == 3'(i)) begin
                    word_ff[i] <= wdata;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Unknown slots read as zero
    wire rd_hit = int'(raddr) < DEPTH;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else begin
            rdata <= rd_hit ? word_ff[raddr] : '0;
        end
    end
endmodule

// [rtl/vdb_pkg.sv]
// Package: constants, types and register map for the valve dead-band auto-calibration block
package vdb_pkg;
    // Data width and store depth
    localparam int XW = 16;
    localparam int NSLOT = 5;
    // APB register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_START = 8'h04;
    localparam logic [7:0] A_STEP = 8'h08;
    localparam logic [7:0] A_THRESH = 8'h0c;
    localparam logic [7:0] A_INTERVAL = 8'h10;
    localparam logic [7:0] A_STATUS = 8'h14;
    localparam logic [7:0] A_PIDX = 8'h18;
    localparam logic [7:0] A_PDATA = 8'h1c;
    localparam logic [7:0] A_SPOOL = 8'h20;
    // CTRL and STATUS bit positions
    localparam int B_CAL_ENTRY = 0;
    localparam int B_BEGIN = 1;
    localparam int B_CALMODE = 0;
    localparam int B_RUNNING = 1;
    localparam int B_DONE = 2;
    localparam int B_ABORTED = 3;
    localparam int B_DIR = 4;
    localparam int B_REFUSED = 5;
    // Parameter indices as seen by software
    localparam logic [XW-1:0] IDX_BACKOFF = 16'h02f6;
    localparam logic [XW-1:0] IDX_DB_L = 16'h02e1;
    localparam logic [XW-1:0] IDX_DB_R = 16'h02e2;
    localparam logic [XW-1:0] IDX_FF_L = 16'h02d9;
    localparam logic [XW-1:0] IDX_FF_R = 16'h02eb;
    // Store slots
    localparam logic [2:0] SL_BACKOFF = 3'h0;
    localparam logic [2:0] SL_DB_L = 3'h1;
    localparam logic [2:0] SL_DB_R = 3'h2;
    localparam logic [2:0] SL_FF_L = 3'h3;
    localparam logic [2:0] SL_FF_R = 3'h4;
    localparam logic [2:0] SL_NONE = 3'h7;
    // Values after reset
    localparam logic [XW-1:0] RST_BACKOFF = 16'h0019;
    localparam logic [XW-1:0] RST_DB_L = 16'hff47;
    localparam logic [XW-1:0] RST_DB_R = 16'h00b9;
    localparam logic [XW-1:0] RST_FF_L = 16'hfc18;
    localparam logic [XW-1:0] RST_FF_R = 16'h03e8;
    localparam logic [NSLOT*XW-1:0] RST_STORE = {RST_FF_R, RST_FF_L, RST_DB_R, RST_DB_L, RST_BACKOFF};
    // Limits of the stored back-off value and of the spool stroke
    localparam logic signed [XW-1:0] BACKOFF_MAX = 16'sh012c;
    localparam logic signed [XW-1:0] SP_MAX = 16'sh03e8;
    // Timebase
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_NS = 1000000;
    localparam int MS_CYCLES = TICK_NS / CLK_PERIOD_NS;

    typedef enum {
        ST_BOOT_R, ST_BOOT_L, ST_IDLE, ST_RD_BO, ST_ARM, ST_STEP,
        ST_RD_DB, ST_WR_DB, ST_RD_FF, ST_WR_FF
    } vdb_state_t;

    typedef enum logic [3:0] {
        MSG_STARTED, MSG_STEP, MSG_FLOW_R, MSG_FLOW_L, MSG_COMPLETE, MSG_ABORT
    } vdb_msg_t;

    typedef struct packed {
        logic [XW-1:0] start;
        logic [XW-1:0] step;
        logic [XW-1:0] thresh;
        logic [XW-1:0] interval;
    } vdb_cmd_t;

    typedef struct packed {
        logic valid;
        logic [XW-1:0] idx;
        logic [XW-1:0] data;
    } vdb_nvm_wr_t;

    typedef struct packed {
        logic valid;
        vdb_msg_t code;
        logic [XW-1:0] setpoint;
    } vdb_status_t;
endpackage

// [verif/vdb_autocal_asserts.sv]
// Concurrent checks on the ports of the auto-calibration engine
`timescale 1ns/1ns
module vdb_autocal_asserts
    import vdb_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pslverr,
    // Sensors and drive
    input wire logic wheel_motion,
    input wire logic [XW-1:0] spool_setpoint,
    // Messages, memory and right dead-band in use
    input wire vdb_status_t status_msg,
    input wire vdb_nvm_wr_t nvm_wr,
    input wire logic nvm_commit,
    input wire logic [XW-1:0] active_db_r
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////
    sequence s_msg(vdb_msg_t c);
        status_msg.valid && status_msg.code == c;
    endsequence
    sequence s_nvm(logic [XW-1:0] i);
        nvm_wr.valid && nvm_wr.idx == i;
    endsequence
    ////////////////////////////////////////////////////////////////
    property p_err_phase;
        pslverr |-> psel && penable;
    endproperty
    a_err_phase: assert property (p_err_phase) else $error("pslverr outside access phase");
    property p_unmapped;
        psel && penable && paddr > A_SPOOL |-> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");
    property p_abort;
        spool_setpoint != '0 && wheel_motion |=> spool_setpoint == '0 and s_msg(MSG_ABORT);
    endproperty
    a_abort: assert property (p_abort) else $error("wheel motion did not abort");
    property p_range;
        $signed(spool_setpoint) <= 1000 && $signed(spool_setpoint) >= -1000;
    endproperty
    a_range: assert property (p_range) else $error("spool beyond stroke");
    property p_flow_r;
        s_msg(MSG_FLOW_R) |-> ##[1:8] s_nvm(IDX_DB_R);
    endproperty
    a_flow_r: assert property (p_flow_r) else $error("right dead-band not stored");
    property p_flow_l;
        s_msg(MSG_FLOW_L) |-> ##[1:8] s_nvm(IDX_DB_L);
    endproperty
    a_flow_l: assert property (p_flow_l) else $error("left dead-band not stored");
    property p_commit;
        nvm_commit |-> s_msg(MSG_COMPLETE);
    endproperty
    a_commit: assert property (p_commit) else $error("commit without completion");
    property p_nvm_pulse;
        nvm_wr.valid |=> !nvm_wr.valid;
    endproperty
    a_nvm_pulse: assert property (p_nvm_pulse) else $error("memory write not a pulse");
    property p_msg_sp;
        s_msg(MSG_STEP) or s_msg(MSG_FLOW_R) or s_msg(MSG_FLOW_L) |->
            status_msg.setpoint == $past(spool_setpoint);
    endproperty
    a_msg_sp: assert property (p_msg_sp) else $error("message set-point wrong");
    property p_active;
        $stable(active_db_r);
    endproperty
    a_active: assert property (p_active) else $error("active dead-band changed");
endmodule

bind vdb_autocal vdb_autocal_asserts u_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .pslverr(pslverr), .wheel_motion(wheel_motion),
    .spool_setpoint(spool_setpoint), .status_msg(status_msg), .nvm_wr(nvm_wr),
    .nvm_commit(nvm_commit), .active_db_r(active_db_r));

// [verif/vdb_autocal_tb.sv]
// Testbench for the auto-calibration engine
`timescale 1ns/1ns
module vdb_autocal_tb
    import vdb_pkg::*;
;
    localparam int HDB = 130;
    localparam int ST = 100;
    localparam int SZ = 10;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, wheel_motion, nvm_commit;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [XW-1:0] wheel_pos, spool_setpoint, active_db_r, active_db_l;
    vdb_status_t status_msg;
    vdb_nvm_wr_t nvm_wr;
    int err_count, check_count, commits;
    int msg_cnt [16];
    logic [XW-1:0] sp_seen [16];
    logic [31:0] nvq [$];
    vdb_autocal #(.TICK_CYCLES(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wheel_pos(wheel_pos), .wheel_motion(wheel_motion),
        .spool_setpoint(spool_setpoint), .status_msg(status_msg), .nvm_wr(nvm_wr),
        .nvm_commit(nvm_commit), .active_db_r(active_db_r), .active_db_l(active_db_l));
    vdb_terminal term (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    always #2 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////
    // Valve and wheel: moves only past the hydraulic dead-band
    always @(posedge pclk) begin
        if ($signed(spool_setpoint) > HDB) wheel_pos <= wheel_pos + 16'h0001;
        else if ($signed(spool_setpoint) < -HDB) wheel_pos <= wheel_pos - 16'h0001;
        if (nvm_wr.valid === 1'b1) nvq.push_back({nvm_wr.idx, nvm_wr.data});
        if (status_msg.valid === 1'b1) msg_cnt[status_msg.code]++;
        if (status_msg.valid === 1'b1) sp_seen[status_msg.code] <= status_msg.setpoint;
        if (nvm_commit === 1'b1) commits++;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        check_count++;
        if (s !== x) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        term.xfer(1'b0, a, 32'h0, q, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        term.xfer(1'b1, a, d, q, e);
    endtask
    task automatic clear();
        nvq.delete();
        commits = 0;
        foreach (msg_cnt[i]) msg_cnt[i] = 0;
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [31:0] q;
        logic e;
        rd(A_STATUS, q);
        chk("status_rst", q, 32'h0);
        term.xfer(1'b0, 8'h40, 32'h0, q, e);
        chk("unmapped_err", e, 1);
        chk("unmapped_data", q, 32'h0);
        wr(A_PIDX, IDX_DB_L);
        rd(A_PDATA, q);
        chk("db_l_rst", q, 32'hffffff47);
        wr(A_PIDX, IDX_BACKOFF);
        rd(A_PDATA, q);
        chk("backoff_rst", q, 32'd25);
        wr(A_PDATA, 32'd301);
        rd(A_PDATA, q);
        chk("backoff_301", q, 32'd25);
        rd(A_STATUS, q);
        chk("refused", q[B_REFUSED], 1);
        wr(A_PDATA, 32'd300);
        rd(A_PDATA, q);
        chk("backoff_300", q, 32'd300);
        wr(A_PDATA, 32'd25);
    endtask
    task automatic t_no_calmode();
        logic [31:0] q;
        clear();
        term.start_cal();
        rd(A_STATUS, q);
        chk("status_nocal", q[5:0], 6'h20);
        chk("started_nocal", msg_cnt[MSG_STARTED], 0);
    endtask
    task automatic t_full_cal();
        logic [31:0] q;
        logic [15:0] fp, db;
        logic [31:0] x [4];
        fp = 16'(ST);
        while ($signed(fp) <= HDB) fp = fp + 16'(SZ);
        db = fp - 16'd25;
        x[0] = {IDX_DB_R, db};
        x[1] = {IDX_FF_R, RST_FF_R + db - RST_DB_R};
        x[2] = {IDX_DB_L, -db};
        x[3] = {IDX_FF_L, RST_FF_L - db - RST_DB_L};
        wr(A_CTRL, 32'h1 << B_CAL_ENTRY);
        wr(A_START, ST);
        wr(A_STEP, SZ);
        wr(A_THRESH, 32'd3);
        wr(A_INTERVAL, 32'd1);
        wr(A_PIDX, IDX_DB_R);
        clear();
        term.start_cal();
        wr(A_PDATA, 32'd50);
        rd(A_PDATA, q);
        chk("pdata_run", q, 32'h0);
        for (int i = 0; i < 300 && q[B_DONE] !== 1'b1; i++) rd(A_STATUS, q);
        chk("status_done", q[3:0], 4'h5);
        chk("nvm_count", nvq.size(), 4);
        for (int i = 0; i < 4; i++) chk("nvm_write", nvq[i], x[i]);
        chk("flow_r", sp_seen[MSG_FLOW_R], fp);
        chk("flow_l", sp_seen[MSG_FLOW_L], 16'(-fp));
        chk("steps", msg_cnt[MSG_STEP], 2 * (fp - ST) / SZ);
        chk("started", msg_cnt[MSG_STARTED], 1);
        chk("complete", msg_cnt[MSG_COMPLETE], 1);
        chk("commit", commits, 1);
        wr(A_PIDX, IDX_BACKOFF);
        rd(A_PDATA, q);
        chk("backoff_kept", q, 32'd25);
        chk("active_db_r", active_db_r, RST_DB_R);
        chk("active_db_l", active_db_l, RST_DB_L);
        chk("spool_idle", spool_setpoint, 16'h0);
    endtask
    task automatic t_abort();
        logic [31:0] q;
        clear();
        term.start_cal();
        for (int i = 0; i < 100 && spool_setpoint === 16'h0; i++) @(posedge pclk);
        wheel_motion <= 1'b1;
        @(posedge pclk);
        wheel_motion <= 1'b0;
        rd(A_STATUS, q);
        chk("status_abort", q[3:0], 4'h9);
        chk("spool_abort", spool_setpoint, 16'h0);
        chk("abort_msg", msg_cnt[MSG_ABORT], 1);
        chk("no_complete", msg_cnt[MSG_COMPLETE], 0);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        results();
    end
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        wheel_motion = 1'b0;
        wheel_pos = 16'h0;
        err_count = 0;
        check_count = 0;
        clear();
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_regs();
        t_no_calmode();
        t_full_cal();
        t_abort();
        results();
    end
endmodule

// [verif/vdb_terminal.sv]
// Operator terminal model: APB master issuing commands
`timescale 1ns/1ns
module vdb_terminal
    import vdb_pkg::*;
(
    // Clock
    input wire logic pclk,
    // APB master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    ////////////////////////////////////////////////////////////////
    // Request held until pready is seen high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic start_cal();
        logic [31:0] q;
        logic e;
        xfer(1'b1, A_CTRL, 32'h1 << B_BEGIN, q, e);
    endtask
endmodule
